// >>> pkg/frse_pkg.sv
// Purpose: shared constants for the flash row erase sequencer, both ends
// Assumes: 125 MHz REF_CLK, 8-bit core register bus with 2-bit register index
// Notes:   What this block does is listed below, one line per rule
//
// What this block does
// - program memory erased only as whole rows
// - software loads address pair inside target row
// - clear config select, set select, erase, enable
// - unlock is 55h then AAh to unlock register
// - start bit after unlock begins row erase
// - erase bit stays set until erase completes
// - two setup cycles; software places two idles
// - core stalled for erase time, typically 2 ms
// - clocks and peripherals keep running during stall
// - core resumes at third instruction after start
// - unlock writes and start run back to back
package frse_pkg;

    // flash register indices on the core bus
    localparam logic [1:0] FRSE_IDX_ADDR_LOW  = 2'h0;
    localparam logic [1:0] FRSE_IDX_ADDR_HIGH = 2'h1;
    localparam logic [1:0] FRSE_IDX_CONTROL   = 2'h2;
    localparam logic [1:0] FRSE_IDX_UNLOCK    = 2'h3;

    // control register fields
    localparam int FRSE_BIT_START      = 1;
    localparam int FRSE_BIT_WR_ENABLE  = 2;
    localparam int FRSE_BIT_ROW_ERASE  = 4;
    localparam int FRSE_BIT_CFG_SELECT = 6;
    localparam int FRSE_BIT_PM_SELECT  = 7;
    localparam logic [7:0] FRSE_CONTROL_RESET = 8'h00;

    // unlock keys
    localparam logic [7:0] FRSE_KEY_FIRST  = 8'h55;
    localparam logic [7:0] FRSE_KEY_SECOND = 8'hAA;

    // timing
    localparam int FRSE_CLK_PERIOD_NS  = 8;
    localparam int FRSE_ERASE_TIME_NS  = 2000000;
    localparam int FRSE_ERASE_CYCLES   = FRSE_ERASE_TIME_NS / FRSE_CLK_PERIOD_NS;
    localparam int FRSE_SETUP_CYCLES   = 2;

    // controller software-side register map
    localparam logic [2:0] FRSE_CREG_COMMAND = 3'h0;
    localparam logic [2:0] FRSE_CREG_ADDR_LO = 3'h1;
    localparam logic [2:0] FRSE_CREG_ADDR_HI = 3'h2;
    localparam logic [2:0] FRSE_CREG_STATUS  = 3'h3;
    localparam logic [2:0] FRSE_CREG_MASK    = 3'h4;
    localparam int FRSE_ST_BUSY    = 0;
    localparam int FRSE_ST_DONE    = 1;
    localparam int FRSE_ST_REFUSED = 2;
    localparam logic [2:0] FRSE_STICKY_MASK = 3'h6;

endpackage

// >>> pkg/frse_if.sv
// Purpose: core-to-flash register bus between the controller and the sequencer
// Assumes: single clock, read data valid the cycle after the read strobe
// Notes:   stall holds the core while a row erase runs
`timescale 1ns/10ps
interface frse_if;
    logic       wr;
    logic       rd;
    logic [1:0] idx;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       stall;

    modport core  (output wr, output rd, output idx, output wdata, input rdata, input stall);
    modport flash (input wr, input rd, input idx, input wdata, output rdata, output stall);
endinterface

// >>> rtl/frse_flash_seq.sv
// Purpose: flash-side row erase sequencer with unlock check and core stall
// Assumes: core bus writes are single-cycle; flash array erases a row on a strobe
// Notes:   only row erase is supported; word programming is not part of this block
`timescale 1ns/10ps
module frse_flash_seq #(
    parameter int ADDR_W       = 15,
    parameter int ROW_LOG2     = 5,
    parameter int ERASE_CYCLES = frse_pkg::FRSE_ERASE_CYCLES
) (
    // clock and reset
    input  wire logic                   REF_CLK,
    input  wire logic                   RSTN,
    // core register bus
    frse_if.flash                       BUS,
    // flash array side
    output logic                        ERASE_STB,
    output logic [ADDR_W-ROW_LOG2-1:0]  ERASE_ROW,
    output logic                        ERASE_BUSY
);
    import frse_pkg::*;

    typedef enum logic [3:0] {
        FRSE_IDLE   = 4'h1,
        FRSE_SETUP  = 4'h2,
        FRSE_ERASE  = 4'h4,
        FRSE_FINISH = 4'h8
    } frse_state_t;

    typedef enum logic [2:0] {
        FRSE_KEY_NONE  = 3'h1,
        FRSE_KEY_HALF  = 3'h2,
        FRSE_KEY_OPEN  = 3'h4
    } frse_key_t;

    ////////////////////////////////////////////////////////////////////////////////
    // decode

    frse_state_t  state_q;
    frse_state_t  state_d;
    frse_key_t    key_q;
    logic [7:0]   addr_low_q;
    logic [7:0]   addr_high_q;
    logic [7:0]   control_q;
    logic [31:0]  count_q;
    logic         busy;
    logic         wr_addr_low;
    logic         wr_addr_high;
    logic         wr_control;
    logic         wr_unlock;
    logic         start_req;
    logic         start_ok;
    logic         count_done;
    logic [ADDR_W-1:0] full_addr;

    assign busy         = (state_q != FRSE_IDLE);
    assign wr_addr_low  = BUS.wr && (BUS.idx == FRSE_IDX_ADDR_LOW);
    assign wr_addr_high = BUS.wr && (BUS.idx == FRSE_IDX_ADDR_HIGH);
    assign wr_control   = BUS.wr && (BUS.idx == FRSE_IDX_CONTROL);
    assign wr_unlock    = BUS.wr && (BUS.idx == FRSE_IDX_UNLOCK);
    assign count_done   = (count_q == 32'h00000000);
    assign full_addr    = ADDR_W'({addr_high_q, addr_low_q});

    // start only counts straight after a complete unlock pair
    assign start_req = wr_control && BUS.wdata[FRSE_BIT_START] && !busy
                       && (key_q == FRSE_KEY_OPEN);

    // row erase needs write enable, program memory and erase selected
    assign start_ok  = start_req
                       && BUS.wdata[FRSE_BIT_WR_ENABLE]
                       && BUS.wdata[FRSE_BIT_ROW_ERASE]
                       && BUS.wdata[FRSE_BIT_PM_SELECT]
                       && !BUS.wdata[FRSE_BIT_CFG_SELECT];

    ////////////////////////////////////////////////////////////////////////////////
    // address pair

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            addr_low_q  <= 8'h00;
            addr_high_q <= 8'h00;
        end else if (!busy) begin
            if (wr_addr_low) begin
                addr_low_q <= BUS.wdata;
            end
            if (wr_addr_high) begin
                addr_high_q <= BUS.wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // unlock tracker: any other write in between closes the lock again

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            key_q <= FRSE_KEY_NONE;
        end else if (BUS.wr) begin
            if (wr_unlock && (BUS.wdata == FRSE_KEY_FIRST)) begin
                key_q <= FRSE_KEY_HALF;
            end else if (wr_unlock && (BUS.wdata == FRSE_KEY_SECOND) && (key_q == FRSE_KEY_HALF)) begin
                key_q <= FRSE_KEY_OPEN;
            end else begin
                key_q <= FRSE_KEY_NONE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // control register

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            control_q <= FRSE_CONTROL_RESET;
        end else if (state_q == FRSE_FINISH) begin
            control_q[FRSE_BIT_ROW_ERASE] <= 1'b0;
            control_q[FRSE_BIT_START]     <= 1'b0;
        end else if (wr_control && !busy) begin
            // start bit only sticks when an erase really begins
            control_q                 <= BUS.wdata;
            control_q[FRSE_BIT_START] <= start_ok;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sequencer

    always_comb begin
        state_d = state_q;
        case (state_q)
            FRSE_IDLE: begin
                if (start_ok) begin
                    state_d = FRSE_SETUP;
                end
            end
            FRSE_SETUP: begin
                if (count_done) begin
                    state_d = FRSE_ERASE;
                end
            end
            FRSE_ERASE: begin
                if (count_done) begin
                    state_d = FRSE_FINISH;
                end
            end
            FRSE_FINISH: begin
                state_d = FRSE_IDLE;
            end
            default: begin
                state_d = FRSE_IDLE;
            end
        endcase
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_q <= FRSE_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // one counter serves setup and erase phases
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            count_q <= 32'h00000000;
        end else if (state_q == FRSE_IDLE && start_ok) begin
            count_q <= 32'(FRSE_SETUP_CYCLES - 1);
        end else if (state_q == FRSE_SETUP && count_done) begin
            count_q <= 32'(ERASE_CYCLES - 1);
        end else if (!count_done) begin
            count_q <= count_q - 32'h00000001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // core stall and array strobe
    // only instruction fetch is held; the clock never stops, so timers
    // and other peripherals keep counting through the erase

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            BUS.stall <= 1'b0;
        end else begin
            BUS.stall <= (state_d == FRSE_ERASE);
        end
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ERASE_STB <= 1'b0;
            ERASE_ROW <= '0;
        end else begin
            ERASE_STB <= (state_q == FRSE_SETUP) && count_done;
            if ((state_q == FRSE_SETUP) && count_done) begin
                // low address bits are dropped: the whole row goes
                ERASE_ROW <= full_addr[ADDR_W-1:ROW_LOG2];
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ERASE_BUSY <= 1'b0;
        end else begin
            ERASE_BUSY <= (state_d != FRSE_IDLE);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read port

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            BUS.rdata <= 8'h00;
        end else if (BUS.rd) begin
            case (BUS.idx)
                FRSE_IDX_ADDR_LOW: begin
                    BUS.rdata <= addr_low_q;
                end
                FRSE_IDX_ADDR_HIGH: begin
                    BUS.rdata <= addr_high_q;
                end
                FRSE_IDX_CONTROL: begin
                    BUS.rdata <= control_q;
                end
                default: begin
                    BUS.rdata <= 8'h00;
                end
            endcase
        end
    end

endmodule

// >>> rtl/frse_core_ctrl.sv
// Purpose: core-side controller running the row erase software sequence
// Assumes: software drives a plain strobe port; read data one cycle later
// Notes:   the full unlock-and-start run is issued back to back
`timescale 1ns/10ps
module frse_core_ctrl (
    // clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RSTN,
    // software register port
    input  wire logic [2:0]  ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [7:0]  RDATA,
    output logic             IRQ,
    // flash register bus
    frse_if.core             BUS
);
    import frse_pkg::*;

    typedef enum logic [10:0] {
        FRSE_C_IDLE  = 11'h001,
        FRSE_C_ADRL  = 11'h002,
        FRSE_C_ADRH  = 11'h004,
        FRSE_C_CTRL  = 11'h008,
        FRSE_C_KEY1  = 11'h010,
        FRSE_C_KEY2  = 11'h020,
        FRSE_C_START = 11'h040,
        FRSE_C_NOP   = 11'h080,
        FRSE_C_HOLD  = 11'h100,
        FRSE_C_POLL  = 11'h200,
        FRSE_C_CHECK = 11'h400
    } frse_cstate_t;

    frse_cstate_t state_q;
    logic [7:0]   row_lo_q;
    logic [7:0]   row_hi_q;
    logic [2:0]   sticky_q;
    logic [2:0]   mask_q;
    logic         nop_q;
    logic         cmd_go;
    logic         done_evt;
    logic [7:0]   ctl_base;

    assign cmd_go   = WR && (ADDR == FRSE_CREG_COMMAND) && WDATA[0];
    assign done_evt = (state_q == FRSE_C_CHECK) && !BUS.rdata[FRSE_BIT_ROW_ERASE];
    assign ctl_base = 8'h00 | (8'h01 << FRSE_BIT_PM_SELECT) | (8'h01 << FRSE_BIT_ROW_ERASE)
                      | (8'h01 << FRSE_BIT_WR_ENABLE);

    ////////////////////////////////////////////////////////////////////////////////
    // software registers

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            row_lo_q <= 8'h00;
            row_hi_q <= 8'h00;
            mask_q   <= 3'h0;
        end else if (WR) begin
            case (ADDR)
                FRSE_CREG_ADDR_LO: row_lo_q <= WDATA;
                FRSE_CREG_ADDR_HI: row_hi_q <= WDATA;
                FRSE_CREG_MASK:    mask_q   <= WDATA[2:0];
                default:           mask_q   <= mask_q;
            endcase
        end
    end

    // read clears the sticky bits, but a same-cycle event still lands
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            sticky_q <= 3'h0;
        end else begin
            sticky_q <= (RD && ADDR == FRSE_CREG_STATUS) ? 3'h0 : sticky_q;
            if (done_evt) begin
                sticky_q[FRSE_ST_DONE] <= 1'b1;
            end
            if (cmd_go && state_q != FRSE_C_IDLE) begin
                sticky_q[FRSE_ST_REFUSED] <= 1'b1;
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            RDATA <= 8'h00;
            IRQ   <= 1'b0;
        end else begin
            IRQ <= |(sticky_q & mask_q & FRSE_STICKY_MASK);
            if (RD) begin
                case (ADDR)
                    FRSE_CREG_ADDR_LO: RDATA <= row_lo_q;
                    FRSE_CREG_ADDR_HI: RDATA <= row_hi_q;
                    FRSE_CREG_STATUS:  RDATA <= {5'h00, sticky_q[2:1], state_q != FRSE_C_IDLE};
                    FRSE_CREG_MASK:    RDATA <= {5'h00, mask_q};
                    default:           RDATA <= 8'h00;
                endcase
            end else begin
                RDATA <= 8'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // erase sequence

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_q <= FRSE_C_IDLE;
            nop_q   <= 1'b0;
        end else begin
            case (state_q)
                FRSE_C_IDLE:  if (cmd_go) state_q <= FRSE_C_ADRL;
                FRSE_C_ADRL:  state_q <= FRSE_C_ADRH;
                FRSE_C_ADRH:  state_q <= FRSE_C_CTRL;
                FRSE_C_CTRL:  state_q <= FRSE_C_KEY1;
                FRSE_C_KEY1:  state_q <= FRSE_C_KEY2;
                FRSE_C_KEY2:  state_q <= FRSE_C_START;
                FRSE_C_START: begin
                    state_q <= FRSE_C_NOP;
                    nop_q   <= 1'b0;
                end
                FRSE_C_NOP: begin
                    nop_q <= 1'b1;
                    if (nop_q) state_q <= FRSE_C_HOLD;
                end
                FRSE_C_HOLD:  if (!BUS.stall) state_q <= FRSE_C_POLL;
                FRSE_C_POLL:  state_q <= FRSE_C_CHECK;
                FRSE_C_CHECK: state_q <= done_evt ? FRSE_C_IDLE : FRSE_C_POLL;
                default:      state_q <= FRSE_C_IDLE;
            endcase
        end
    end

    // bus drive is decoded from the current state and registered, so it shows in the next state
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            BUS.wr    <= 1'b0;
            BUS.rd    <= 1'b0;
            BUS.idx   <= 2'h0;
            BUS.wdata <= 8'h00;
        end else begin
            BUS.wr    <= 1'b0;
            BUS.rd    <= 1'b0;
            BUS.idx   <= 2'h0;
            BUS.wdata <= 8'h00;
            case (state_q)
                FRSE_C_IDLE: if (cmd_go) begin
                    BUS.wr <= 1'b1;
                    BUS.idx <= FRSE_IDX_ADDR_LOW;
                    BUS.wdata <= row_lo_q;
                end
                FRSE_C_ADRL: begin
                    BUS.wr <= 1'b1;
                    BUS.idx <= FRSE_IDX_ADDR_HIGH;
                    BUS.wdata <= row_hi_q;
                end
                FRSE_C_ADRH: begin
                    BUS.wr <= 1'b1;
                    BUS.idx <= FRSE_IDX_CONTROL;
                    BUS.wdata <= ctl_base;
                end
                FRSE_C_CTRL: begin
                    BUS.wr <= 1'b1;
                    BUS.idx <= FRSE_IDX_UNLOCK;
                    BUS.wdata <= FRSE_KEY_FIRST;
                end
                FRSE_C_KEY1: begin
                    BUS.wr <= 1'b1;
                    BUS.idx <= FRSE_IDX_UNLOCK;
                    BUS.wdata <= FRSE_KEY_SECOND;
                end
                FRSE_C_KEY2: begin
                    BUS.wr    <= 1'b1;
                    BUS.idx   <= FRSE_IDX_CONTROL;
                    BUS.wdata <= ctl_base | (8'h01 << FRSE_BIT_START);
                end
                FRSE_C_HOLD: if (!BUS.stall) begin
                    BUS.rd <= 1'b1;
                    BUS.idx <= FRSE_IDX_CONTROL;
                end
                FRSE_C_CHECK: if (!done_evt) begin
                    BUS.rd <= 1'b1;
                    BUS.idx <= FRSE_IDX_CONTROL;
                end
                default: BUS.wr <= 1'b0;
            endcase
        end
    end

endmodule

// >>> dv/frse_bus_properties.sv
// Purpose: concurrent checks on the core-to-flash bus joining both ends
// Assumes: one clock domain; keys, indices and control bits from frse_pkg
// Notes:   sees the bus only; the array side is judged by the bench
`timescale 1ns/10ps
module frse_bus_properties #(
    parameter int ERASE_CYCLES = frse_pkg::FRSE_ERASE_CYCLES
) (
    // clock and reset
    input wire logic       REF_CLK,
    input wire logic       RSTN,
    // core-to-flash bus
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [1:0] idx,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic       stall
);
    import frse_pkg::*;

    logic [1:0] key_q;
    int         stall_cnt_q;
    logic       ctl_wr;
    logic       start_ok;

    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);

    ////////////////////////////////////////
    // unlock progress: any other write in between drops it, reads do not
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN)
            key_q <= 2'h0;
        else if (wr && idx == FRSE_IDX_UNLOCK && wdata == FRSE_KEY_FIRST)
            key_q <= 2'h1;
        else if (wr && idx == FRSE_IDX_UNLOCK && wdata == FRSE_KEY_SECOND && key_q == 2'h1)
            key_q <= 2'h2;
        else if (wr)
            key_q <= 2'h0;
    end

    // length of the current stall run, one cycle late; back to zero one cycle after it ends
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN)
            stall_cnt_q <= 0;
        else
            stall_cnt_q <= stall ? stall_cnt_q + 1 : 0;
    end

    assign ctl_wr   = wr && idx == FRSE_IDX_CONTROL;
    assign start_ok = ctl_wr && wdata[FRSE_BIT_START] && wdata[FRSE_BIT_WR_ENABLE] && wdata[FRSE_BIT_ROW_ERASE]
                      && wdata[FRSE_BIT_PM_SELECT] && !wdata[FRSE_BIT_CFG_SELECT] && key_q == 2'h2 && !stall;

    ////////////////////////////////////////
    a_start_then_stall: assert property (start_ok |=> !stall ##1 !stall ##1 stall)
        else $error("stall did not rise after two setup cycles");
    a_stall_length: assert property ($fell(stall) |-> stall_cnt_q == ERASE_CYCLES)
        else $error("stall run length differs from erase time");
    a_core_idles: assert property (start_ok |=> (!wr && !rd) [*2])
        else $error("core accessed the bus during setup");
    a_core_waits: assert property (stall |-> !wr && !rd)
        else $error("core accessed the bus while stalled");
    a_resume_read: assert property ($fell(stall) |-> ##[0:2] (rd && idx == FRSE_IDX_CONTROL))
        else $error("core did not resume promptly after stall");
    a_unlock_order: assert property ((wr && idx == FRSE_IDX_UNLOCK && wdata == FRSE_KEY_FIRST)
        |=> (wr && idx == FRSE_IDX_UNLOCK && wdata == FRSE_KEY_SECOND) ##1 (ctl_wr && wdata[FRSE_BIT_START]))
        else $error("unlock keys and start not back to back");
    a_start_bits: assert property ((ctl_wr && wdata[FRSE_BIT_START]) |-> wdata[FRSE_BIT_WR_ENABLE]
        && wdata[FRSE_BIT_ROW_ERASE] && wdata[FRSE_BIT_PM_SELECT] && !wdata[FRSE_BIT_CFG_SELECT])
        else $error("start written with wrong control bits");
    a_erase_cleared: assert property ($fell(stall) ##1 (rd && idx == FRSE_IDX_CONTROL)
        |=> !rdata[FRSE_BIT_ROW_ERASE] && !rdata[FRSE_BIT_START])
        else $error("erase bit still set after completion");
    a_addr_pair: assert property ((wr && idx == FRSE_IDX_ADDR_LOW) |=> wr && idx == FRSE_IDX_ADDR_HIGH)
        else $error("address high byte did not follow low byte");

    c_start: cover property (start_ok);
    c_resume: cover property ($fell(stall) ##1 (rd && idx == FRSE_IDX_CONTROL));
    c_full_run: cover property (stall_cnt_q == ERASE_CYCLES);
endmodule

// >>> dv/flash_row_erase_sequencer_bench.sv
// Purpose: self-checking bench for controller and sequencer facing each other
// Assumes: erase time shortened to ERASE_N cycles
// Notes:   a second sequencer is driven directly to break the unlock rules
`timescale 1ns/10ps
module flash_row_erase_sequencer_bench;
    import frse_pkg::*;

    localparam int ERASE_N = 20;
    logic       ref_clk, rstn, wr, rd, irq, stb1, busy1, stb2, busy2;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, v;
    logic [9:0] row1, row2;
    int         miscompares, comparisons, stall_run, stb2_count, n, i, j;
    // refused unlock runs: split, reversed, missing, repeated first key
    logic [1:0] seq_idx [4][3] = '{'{2'h3, 2'h0, 2'h3}, '{2'h0, 2'h3, 2'h3}, '{2'h0, 2'h0, 2'h0}, '{2'h0, 2'h3, 2'h3}};
    logic [7:0] seq_dat [4][3] = '{'{8'h55, 8'h20, 8'hAA}, '{8'h20, 8'hAA, 8'h55}, '{8'h20, 8'h20, 8'h20},
                                   '{8'h20, 8'h55, 8'h55}};

    frse_if bus1 ();
    frse_if bus2 ();
    frse_core_ctrl frse_core_ctrl_inst (.REF_CLK(ref_clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .IRQ(irq), .BUS(bus1));
    frse_flash_seq #(.ERASE_CYCLES(ERASE_N)) frse_flash_seq_inst (.REF_CLK(ref_clk), .RSTN(rstn), .BUS(bus1),
        .ERASE_STB(stb1), .ERASE_ROW(row1), .ERASE_BUSY(busy1));
    frse_flash_seq #(.ERASE_CYCLES(ERASE_N)) frse_flash_seq_inst_b (.REF_CLK(ref_clk), .RSTN(rstn), .BUS(bus2),
        .ERASE_STB(stb2), .ERASE_ROW(row2), .ERASE_BUSY(busy2));
    frse_bus_properties #(.ERASE_CYCLES(ERASE_N)) frse_bus_properties_inst (.REF_CLK(ref_clk), .RSTN(rstn),
        .wr(bus1.wr), .rd(bus1.rd), .idx(bus1.idx), .wdata(bus1.wdata), .rdata(bus1.rdata), .stall(bus1.stall));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // running totals; only ever grow, so a stray stall or strobe shows up later
    always @(posedge ref_clk) begin
        if (!rstn) begin
            stall_run  <= 0;
            stb2_count <= 0;
        end else begin
            if (bus1.stall === 1'b1)
                stall_run <= stall_run + 1;
            if (stb2 === 1'b1)
                stb2_count <= stb2_count + 1;
        end
    end

    ////////////////////////////////////////
    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic tick;
        @(posedge ref_clk);
        #1;
    endtask

    task automatic sw_op(input logic is_rd, input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= d;
        wr    <= !is_rd;
        rd    <= is_rd;
        @(posedge ref_clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 q = rdata;
    endtask

    task automatic bus_op(input logic is_rd, input logic [1:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge ref_clk);
        bus2.idx   <= a;
        bus2.wdata <= d;
        bus2.wr    <= !is_rd;
        bus2.rd    <= is_rd;
        @(posedge ref_clk);
        bus2.wr <= 1'b0;
        bus2.rd <= 1'b0;
        #1 q = bus2.rdata;
    endtask

    task automatic wrap_up;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    ////////////////////////////////////////
    initial begin
        #40000;
        miscompares++;
        wrap_up();
    end

    initial begin
        {rstn, wr, rd, addr, wdata, miscompares, comparisons} = '0;
        {bus2.wr, bus2.rd, bus2.idx, bus2.wdata} = '0;
        repeat (5) @(posedge ref_clk);
        rstn <= 1'b1;
        sw_op(1'b1, FRSE_CREG_STATUS, 8'h00, v);
        check_val(16'(v), 16'h0000);
        check_val(16'({irq, busy1, stb1}), 16'h0000);
        $display("test reset finished");

        // full erase with the done event unmasked
        sw_op(1'b0, FRSE_CREG_MASK, 8'h07, v);
        sw_op(1'b0, FRSE_CREG_ADDR_LO, 8'hA5, v);
        sw_op(1'b0, FRSE_CREG_ADDR_HI, 8'hBC, v);
        sw_op(1'b0, FRSE_CREG_COMMAND, 8'h01, v);
        for (n = 0; n < 100 && stb1 !== 1'b1; n++) tick();
        check_val(16'(row1), 16'h01E5);
        check_val(16'(bus1.stall), 16'h0001);
        sw_op(1'b1, FRSE_CREG_STATUS, 8'h00, v);
        check_val(16'(v), 16'h0001);
        for (n = 0; n < 100 && irq !== 1'b1; n++) tick();
        check_val(16'({irq, busy1}), 16'h0002);
        check_val(16'(stall_run), 16'(ERASE_N));
        sw_op(1'b1, FRSE_CREG_STATUS, 8'h00, v);
        check_val(16'(v), 16'h0002);
        repeat (2) tick();
        check_val(16'(irq), 16'h0000);
        $display("test full erase finished");

        // back-to-back commands: second refused; done masked
        sw_op(1'b0, FRSE_CREG_MASK, 8'h04, v);
        sw_op(1'b0, FRSE_CREG_COMMAND, 8'h01, v);
        sw_op(1'b0, FRSE_CREG_COMMAND, 8'h01, v);
        for (n = 0; n < 20 && irq !== 1'b1; n++) tick();
        sw_op(1'b1, FRSE_CREG_STATUS, 8'h00, v);
        check_val(16'(v), 16'h0005);
        for (n = 0; n < 20 && busy1 !== 1'b1; n++) tick();
        for (n = 0; n < 100 && busy1 !== 1'b0; n++) tick();
        repeat (10) tick();
        check_val(16'(irq), 16'h0000);
        sw_op(1'b1, FRSE_CREG_STATUS, 8'h00, v);
        check_val(16'(v), 16'h0002);
        check_val(16'(stall_run), 16'(2 * ERASE_N));
        $display("test refused command finished");

        // broken unlock runs on the directly driven sequencer
        bus_op(1'b0, FRSE_IDX_ADDR_LOW, 8'h20, v);
        bus_op(1'b0, FRSE_IDX_ADDR_HIGH, 8'h01, v);
        for (i = 0; i < 4; i++) begin
            bus_op(1'b0, FRSE_IDX_CONTROL, 8'h94, v);
            for (j = 0; j < 3; j++) bus_op(1'b0, seq_idx[i][j], seq_dat[i][j], v);
            bus_op(1'b0, FRSE_IDX_CONTROL, 8'h96, v);
            repeat (4) tick();
            check_val(16'(bus2.stall), 16'h0000);
            bus_op(1'b1, FRSE_IDX_CONTROL, 8'h00, v);
            check_val(16'(v), 16'h0094);
        end
        // valid keys but write enable clear
        bus_op(1'b0, FRSE_IDX_CONTROL, 8'h90, v);
        bus_op(1'b0, FRSE_IDX_UNLOCK, FRSE_KEY_FIRST, v);
        bus_op(1'b0, FRSE_IDX_UNLOCK, FRSE_KEY_SECOND, v);
        bus_op(1'b0, FRSE_IDX_CONTROL, 8'h92, v);
        repeat (4) tick();
        bus_op(1'b1, FRSE_IDX_CONTROL, 8'h00, v);
        check_val(16'(v), 16'h0090);
        check_val(16'(stb2_count), 16'h0000);
        $display("test broken unlock finished");

        // valid run, erase bit polled while running and after
        bus_op(1'b0, FRSE_IDX_CONTROL, 8'h94, v);
        bus_op(1'b0, FRSE_IDX_UNLOCK, FRSE_KEY_FIRST, v);
        bus_op(1'b0, FRSE_IDX_UNLOCK, FRSE_KEY_SECOND, v);
        bus_op(1'b0, FRSE_IDX_CONTROL, 8'h96, v);
        bus_op(1'b1, FRSE_IDX_CONTROL, 8'h00, v);
        check_val(16'(v[FRSE_BIT_ROW_ERASE]), 16'h0001);
        for (n = 0; n < 100 && busy2 !== 1'b0; n++) tick();
        repeat (2) tick();
        bus_op(1'b1, FRSE_IDX_CONTROL, 8'h00, v);
        check_val(16'(v & 8'h12), 16'h0000);
        check_val(16'(stb2_count), 16'h0001);
        check_val(16'(row2), 16'h0009);
        $display("test direct erase finished");
        wrap_up();
    end
endmodule
